// [core/ric_pkg.sv]
// Contract
// [RQ1] reset comes from the pin, address trap, watchdog or bad clock setting
// [RQ2] a malfunction reset holds internal reset and pin low for 24 cycles
// [RQ3] the malfunction stretcher may fire once at power-up, pin low meanwhile
// [RQ4] pin low for at least 12 cycles applies reset and initialises state
// [RQ5] on pin release execution starts from the vector at the top two bytes
// [RQ6] reset clears master enable, enables, latches; prescaler cleared
// [RQ7] fetch from special register area, or RAM when selected, is a trap
// [RQ8] trap action select defaults to reset; zero makes it an interrupt
// [RQ9] watchdog action select defaults to reset; zero makes it an interrupt
// [RQ10] clearing the running oscillator's enable gives a system clock reset
// [RQ11] eighteen sources; four internal ones are non-maskable
// [RQ12] a request sets its pending latch, which asks the core to accept
// [RQ13] simultaneous requests are taken by fixed priority; nesting allowed
// [RQ14] traps share vector fffc; address trap bit 2, watchdog bit 3; code vectors bits 2 and 3 to fffa and fff8
// [RQ15] maskable needs master and own enable; source 0 also needs its gate
// [RQ16] latch bits 5 to 15 vector downward by two from fff4 to ffe0
// [RQ17] levels 14 and 15 pick pin source or transmit/converter by select bit
// [RQ18] a latch clears at once when the core accepts its interrupt
// [RQ19] accept stacks master enable then clears it; return restores it
// [RQ20] writing zero clears a latch, writing one leaves it unchanged
package ric_pkg;

   // cycle counts; the core clock is the main clock fc
   localparam int STRETCH_PERIODS = 24;
   localparam int EXT_LOW_PERIODS = 12;
   localparam logic [4:0] STRETCH_CYC = 5'(STRETCH_PERIODS);
   localparam logic [3:0] EXT_LOW_CYC = 4'(EXT_LOW_PERIODS);

   // register byte offsets
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PEND = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_SYS = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;

   // configuration bits and reset values
   localparam int CFG_TRAP_ACT = 0;
   localparam int CFG_WDOG_ACT = 1;
   localparam int CFG_RAM_SEL = 2;
   localparam int CFG_EXT0 = 3;
   localparam int CFG_LVL14 = 4;
   localparam int CFG_LVL15 = 5;
   localparam logic [7:0] CFG_RST = 8'h03;
   localparam int SYS_FAST = 0;
   localparam int SYS_SLOW = 1;
   localparam int SYS_SEL = 2;
   localparam logic [7:0] SYS_RST = 8'h01;

   // masks of implemented bits and of the non-maskable latch bits
   localparam logic [15:0] EF_MASK = 16'hfff0;
   localparam logic [15:0] LAT_MASK = 16'hfffc;
   localparam logic [15:0] NMI_MASK = 16'h000c;

   // source indices; vector of index i is top minus 2*i
   localparam logic [3:0] IDX_SOFT = 4'h1;
   localparam logic [3:0] IDX_EXT0 = 4'h4;
   localparam logic [15:0] VEC_TOP = 16'hfffe;

   // fetch address areas
   localparam logic [15:0] SFR_HI = 16'h003f;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h083f;

   // peripheral request pulses
   typedef struct packed {
      logic ext0;
      logic ext1;
      logic base_timer;
      logic timer1;
      logic ext2;
      logic timer4;
      logic timer3;
      logic ext3;
      logic serial;
      logic receive;
      logic ext4;
      logic transmit;
      logic ext5;
      logic converter;
   } ric_src_t;

   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      return VEC_TOP - {11'h000, idx, 1'b0};
   endfunction

   // byte-lane merge of a write into the low 16 bits
   function automatic logic [15:0] be_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

endpackage

// [core/ric_prio.sv]
`timescale 1ns/1ps
`default_nettype none
module ric_prio (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] req,
   output logic found,
   output logic [3:0] idx
);
   // lowest index is highest priority; software and opcode traps share index 1
   always_comb begin
      found = 1'b0;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1; // see [RQ13]
            idx = 4'(i);
         end
      end
   end

   a_prio_lowest: assert property (@(posedge mclk) disable iff (rst) // see [RQ13]
      found |-> req[idx] && (req & ((16'h0001 << idx) - 16'h0001)) == 16'h0)
      else $error("lower index request skipped");
endmodule
`default_nettype wire

// [core/ric_stretch.sv]
`timescale 1ns/1ps
`default_nettype none
module ric_stretch (
   input wire logic mclk,
   input wire logic rst,
   input wire logic trig,
   output logic active_ff
);
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;

   // reload on each request, count down to idle
   assign nxt_cnt = trig ? ric_pkg::STRETCH_CYC :
                    (cnt_ff != 5'h00) ? cnt_ff - 5'h01 : 5'h00;

   // reset starts one stretch, as a cold stretcher would
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_ff <= ric_pkg::STRETCH_CYC; // see [RQ3]
         active_ff <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt; // see [RQ2]
         active_ff <= nxt_cnt != 5'h00;
      end
   end

   a_stretch_load: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
      trig |=> active_ff && cnt_ff == ric_pkg::STRETCH_CYC)
      else $error("stretch not loaded");
   a_stretch_end: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
      !trig && cnt_ff == 5'h01 |=> !active_ff)
      else $error("stretch overran");
endmodule
`default_nettype wire

// [core/ric_top.sv]
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ric_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic soft_trap,
   input wire logic illegal_opcode_trap,
   input wire logic wdog_overflow,
   input wire ric_pkg::ric_src_t src,
   input wire logic irq_ack,
   input wire logic reti_valid,
   input wire logic reti_ime,
   output logic irq_req,
   output logic [15:0] irq_vector,
   output logic irq_ime_stacked,
   output logic core_rst,
   output logic cpu_start,
   input wire logic rst_pin_in_n,
   output logic rst_pin_out,
   output logic rst_pin_oe
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic wait_ff;
   logic [31:0] readdata_ff;
   logic ime_ff;
   logic [15:0] ef_ff;
   logic [15:0] lat_ff;
   logic [7:0] cfg_ff;
   logic [7:0] sys_ff;
   logic [3:0] cause_ff;
   logic swi_hold_ff;
   logic [3:0] low_cnt_ff;
   logic ext_active_ff;
   logic irq_req_ff;
   logic [3:0] idx_ff;
   logic [15:0] vec_ff;
   logic stacked_ff;
   logic core_rst_ff;
   logic start_ff;
   logic mal_active;

   ////////////////////////////////////////////////////////////////////////
   // reset sources
   wire logic pin_low;
   wire logic in_reset;
   wire logic [3:0] nxt_low_cnt;
   wire logic in_sfr;
   wire logic in_ram;
   wire logic trap_hit;
   wire logic trap_rst;
   wire logic trap_irq;
   wire logic wdog_rst;
   wire logic wdog_irq;
   wire logic sys_bad;
   wire logic mal_req;

   localparam logic [3:0] EXT_LOW = ric_pkg::EXT_LOW_CYC;
   // our own drive is masked so a stretch does not extend itself
   assign pin_low = !rst_pin_in_n && !mal_active;
   assign nxt_low_cnt = !pin_low ? 4'h0 :
                        (low_cnt_ff == EXT_LOW) ? low_cnt_ff :
                        low_cnt_ff + 4'h1;
   assign in_reset = rst | mal_active | ext_active_ff; // see [RQ1]

   // address trap areas
   assign in_sfr = fetch_addr <= ric_pkg::SFR_HI;
   assign in_ram = fetch_addr >= ric_pkg::RAM_LO &&
                   fetch_addr <= ric_pkg::RAM_HI;
   assign trap_hit = fetch_valid && !in_reset &&
                     (in_sfr || (in_ram && cfg_ff[ric_pkg::CFG_RAM_SEL])); // see [RQ7]
   assign trap_rst = trap_hit && cfg_ff[ric_pkg::CFG_TRAP_ACT]; // see [RQ8]
   assign trap_irq = trap_hit && !cfg_ff[ric_pkg::CFG_TRAP_ACT];
   assign wdog_rst = wdog_overflow && !in_reset &&
                     cfg_ff[ric_pkg::CFG_WDOG_ACT]; // see [RQ9]
   assign wdog_irq = wdog_overflow && !in_reset &&
                     !cfg_ff[ric_pkg::CFG_WDOG_ACT];
   assign mal_req = trap_rst | wdog_rst | sys_bad; // see [RQ1]

   // malfunction reset stretcher
   ric_stretch u_stretch (
      .mclk(mclk),
      .rst(rst),
      .trig(mal_req),
      .active_ff(mal_active)
   );

   // external pin filter, needs a run of low samples
   always_ff @(posedge mclk) begin
      if (rst) begin
         low_cnt_ff <= 4'h0;
         ext_active_ff <= 1'b0;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
         ext_active_ff <= nxt_low_cnt == EXT_LOW; // see [RQ4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire logic bus_req;
   wire logic bus_take;
   wire logic wr_any;
   wire logic wr_en;
   wire logic wr_pend;
   wire logic wr_cfg;
   wire logic wr_sys;
   wire logic [15:0] wd;
   wire logic [1:0] be;
   wire logic [15:0] be_bits;
   wire logic [15:0] en_wr;
   wire logic [15:0] cfg_wr;
   wire logic [15:0] sys_wr;
   wire logic fast_clr;
   wire logic slow_clr;
   wire logic [15:0] stat_word;
   wire logic [15:0] rd_mux;

   assign bus_req = avs_read | avs_write;
   assign bus_take = bus_req && !wait_ff;
   assign wr_any = bus_take && avs_write && !in_reset;
   assign wr_en = wr_any && avs_address == ric_pkg::OFS_ENABLE;
   assign wr_pend = wr_any && avs_address == ric_pkg::OFS_PEND;
   assign wr_cfg = wr_any && avs_address == ric_pkg::OFS_CFG;
   assign wr_sys = wr_any && avs_address == ric_pkg::OFS_SYS;
   assign wd = avs_writedata[15:0];
   assign be = avs_byteenable[1:0];
   assign be_bits = {{8{be[1]}}, {8{be[0]}}};
   assign en_wr = ric_pkg::be_merge({ef_ff[15:1], ime_ff}, wd, be);
   assign cfg_wr = ric_pkg::be_merge({8'h00, cfg_ff}, wd, be);
   assign sys_wr = ric_pkg::be_merge({8'h00, sys_ff}, wd, be);

   // bad clock switch: the write is dropped, then the malfunction reset reloads SYS_RST, fast clock only
   assign fast_clr = sys_ff[ric_pkg::SYS_FAST] && !sys_wr[ric_pkg::SYS_FAST];
   assign slow_clr = sys_ff[ric_pkg::SYS_SLOW] && !sys_wr[ric_pkg::SYS_SLOW];
   assign sys_bad = wr_sys && ((fast_clr && slow_clr) ||
                    (fast_clr && !sys_ff[ric_pkg::SYS_SEL]) ||
                    (slow_clr && sys_ff[ric_pkg::SYS_SEL])); // see [RQ10]

   assign stat_word = {irq_req_ff, 3'h0, idx_ff, 4'h0, cause_ff};
   assign rd_mux =
      (avs_address == ric_pkg::OFS_ENABLE) ? {ef_ff[15:1], ime_ff} :
      (avs_address == ric_pkg::OFS_PEND) ? lat_ff :
      (avs_address == ric_pkg::OFS_CFG) ? {8'h00, cfg_ff} :
      (avs_address == ric_pkg::OFS_SYS) ? {8'h00, sys_ff} :
      (avs_address == ric_pkg::OFS_STAT) ? stat_word : 16'h0000;

   // one wait cycle per access; read data captured with the ready
   always_ff @(posedge mclk) begin
      if (rst) begin
         wait_ff <= 1'b1;
         readdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= !(bus_req && wait_ff);
         if (bus_req && wait_ff && avs_read) begin
            readdata_ff <= {16'h0000, rd_mux};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pending latches
   wire logic ack_take;
   wire logic lvl14;
   wire logic lvl15;
   wire logic [15:0] lat_set;
   wire logic [15:0] lat_clr;
   wire logic [15:0] nxt_lat;

   assign ack_take = irq_ack && irq_req_ff;
   assign lvl14 = cfg_ff[ric_pkg::CFG_LVL14] ? src.transmit : src.ext4; // see [RQ17]
   assign lvl15 = cfg_ff[ric_pkg::CFG_LVL15] ? src.converter : src.ext5; // see [RQ17]
   assign lat_set = {lvl15, lvl14, src.receive, src.serial, src.ext3,
                     src.timer3, src.timer4, src.ext2, src.timer1,
                     src.base_timer, src.ext1, src.ext0,
                     wdog_irq, trap_irq, 2'b00}; // see [RQ12] [RQ14] [RQ16]
   // written zeros clear, ones are ignored
   assign lat_clr = (wr_pend ? (~wd & be_bits) : 16'h0000) | // see [RQ20]
                    (ack_take ? (16'h0001 << idx_ff) : 16'h0000); // see [RQ18]
   // a request in the clearing cycle survives
   assign nxt_lat = in_reset ? 16'h0000 :
                    ((lat_ff & ~lat_clr) | lat_set) & ric_pkg::LAT_MASK; // see [RQ6]

   ////////////////////////////////////////////////////////////////////////
   // enables and configuration
   wire logic nxt_ime;
   wire logic [15:0] nxt_ef;
   wire logic [7:0] nxt_cfg;
   wire logic [7:0] nxt_sys;
   wire logic nxt_swi;

   // accept beats return, return beats a software write
   assign nxt_ime = in_reset ? 1'b0 : // see [RQ6]
                    ack_take ? 1'b0 : // see [RQ19]
                    reti_valid ? reti_ime : // see [RQ19]
                    wr_en ? en_wr[0] : ime_ff;
   assign nxt_ef = in_reset ? 16'h0000 :
                   wr_en ? (en_wr & ric_pkg::EF_MASK) : ef_ff; // see [RQ6]
   assign nxt_cfg = in_reset ? ric_pkg::CFG_RST : // see [RQ8] [RQ9]
                    wr_cfg ? cfg_wr[7:0] : cfg_ff;
   assign nxt_sys = in_reset ? ric_pkg::SYS_RST :
                    (wr_sys && !sys_bad) ? sys_wr[7:0] : sys_ff;
   // software and opcode traps carry no visible latch, only a hold until accepted
   assign nxt_swi = in_reset ? 1'b0 :
                    (swi_hold_ff && !(ack_take && idx_ff == ric_pkg::IDX_SOFT))
                    || soft_trap || illegal_opcode_trap; // see [RQ14]

   always_ff @(posedge mclk) begin
      if (rst) begin
         ime_ff <= 1'b0;
         ef_ff <= 16'h0000;
         lat_ff <= 16'h0000;
         cfg_ff <= ric_pkg::CFG_RST;
         sys_ff <= ric_pkg::SYS_RST;
         swi_hold_ff <= 1'b0;
      end else begin
         ime_ff <= nxt_ime;
         ef_ff <= nxt_ef;
         lat_ff <= nxt_lat;
         cfg_ff <= nxt_cfg;
         sys_ff <= nxt_sys;
         swi_hold_ff <= nxt_swi;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request selection, computed from next state so an accepted source
   // never shows for an extra cycle
   wire logic [15:0] mask_en;
   wire logic [15:0] elig_raw;
   wire logic [15:0] elig;
   wire logic found;
   wire logic [3:0] idx;

   assign mask_en = nxt_ef & {16{nxt_ime}};
   assign elig_raw = nxt_lat & (mask_en | ric_pkg::NMI_MASK); // see [RQ11] [RQ15]
   assign elig = {elig_raw[15:5],
                  elig_raw[4] && nxt_cfg[ric_pkg::CFG_EXT0], // see [RQ15]
                  elig_raw[3:2], nxt_swi, 1'b0};

   ric_prio u_prio (
      .mclk(mclk),
      .rst(rst),
      .req(elig),
      .found(found),
      .idx(idx)
   );

   // request, vector and reset status to the core
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_req_ff <= 1'b0;
         idx_ff <= 4'h0;
         vec_ff <= ric_pkg::VEC_TOP;
         stacked_ff <= 1'b0;
         core_rst_ff <= 1'b1;
         start_ff <= 1'b0;
         cause_ff <= 4'h0;
      end else begin
         irq_req_ff <= found && !in_reset; // see [RQ13]
         idx_ff <= idx;
         vec_ff <= in_reset ? ric_pkg::VEC_TOP : ric_pkg::vec_of(idx); // see [RQ5]
         stacked_ff <= ack_take ? ime_ff : stacked_ff; // see [RQ19]
         core_rst_ff <= in_reset; // see [RQ6]
         start_ff <= core_rst_ff && !in_reset; // see [RQ5]
         if (mal_req) begin
            cause_ff <= {sys_bad, wdog_rst, trap_rst, 1'b0};
         end else if (ext_active_ff) begin
            cause_ff <= 4'h1;
         end
      end
   end

   // open-drain reset pin, only ever pulled low
   logic pin_oe_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_oe_ff <= 1'b1;
      end else begin
         pin_oe_ff <= mal_active; // see [RQ2] [RQ3]
      end
   end

   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = wait_ff;
   assign irq_req = irq_req_ff;
   assign irq_vector = vec_ff;
   assign irq_ime_stacked = stacked_ff;
   assign core_rst = core_rst_ff;
   assign cpu_start = start_ff;
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = pin_oe_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_mal_stretch: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
      mal_req |=> mal_active [*8])
      else $error("malfunction reset not held");
   a_ext_filter: assert property (@(posedge mclk) disable iff (rst) // see [RQ4]
      $rose(ext_active_ff) |-> $past(pin_low, 1) && $past(pin_low, 12))
      else $error("pin reset too early");
   a_start_vec: assert property (@(posedge mclk) disable iff (rst) // see [RQ5]
      cpu_start |-> irq_vector == ric_pkg::VEC_TOP && !core_rst)
      else $error("start without reset vector");
   a_reset_clear: assert property (@(posedge mclk) disable iff (rst) // see [RQ6]
      in_reset |=> !ime_ff && ef_ff == 16'h0 && lat_ff == 16'h0)
      else $error("reset left state set");
   a_act_default: assert property (@(posedge mclk) disable iff (rst) // see [RQ8]
      in_reset |=> cfg_ff[ric_pkg::CFG_TRAP_ACT] && cfg_ff[ric_pkg::CFG_WDOG_ACT])
      else $error("action selects not defaulted");
   a_mask_gate: assert property (@(posedge mclk) disable iff (rst) // see [RQ15]
      irq_req && idx_ff >= ric_pkg::IDX_EXT0 |-> ime_ff && ef_ff[idx_ff])
      else $error("masked source requested");
   a_ack_clears: assert property (@(posedge mclk) disable iff (rst) // see [RQ18]
      ack_take && idx_ff > ric_pkg::IDX_SOFT && !lat_set[idx_ff]
      |=> !lat_ff[$past(idx_ff)])
      else $error("accepted latch not cleared");
   a_ime_stack: assert property (@(posedge mclk) disable iff (rst) // see [RQ19]
      ack_take |=> !ime_ff && irq_ime_stacked == $past(ime_ff))
      else $error("master enable not stacked");
   a_no_sw_set: assert property (@(posedge mclk) disable iff (rst) // see [RQ20]
      1'b1 |=> (lat_ff & ~$past(lat_ff | lat_set)) == 16'h0)
      else $error("latch set without request");

   c_accept: cover property (@(posedge mclk) disable iff (rst) ack_take);
   c_mal: cover property (@(posedge mclk) disable iff (rst) $rose(mal_active));
   c_pin: cover property (@(posedge mclk) disable iff (rst) $rose(ext_active_ff));
   c_nest: cover property (@(posedge mclk) disable iff (rst)
      ack_take ##[1:20] ack_take);
endmodule
`default_nettype wire

// [test/reset_and_interrupt_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control_tb_top;
   logic mclk, rst, rd, wr, fv, sw, ill, wdo, ack_en, ext_low, reti;
   logic [7:0] adr;
   logic [31:0] wd;
   logic [15:0] fa;
   ric_pkg::ric_src_t src;
   wire logic [31:0] rdat;
   wire logic [15:0] vec;
   wire logic wt, ack, req, ime_st, crst, start, pin_n, poe;
   logic [15:0] acc_q[$];
   int cyc = 0, oe_cnt = 0, n_fail = 0, checks = 0;

   ric_top i_ric_top (.mclk(mclk), .rst(rst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'h3), .avs_readdata(rdat), .avs_waitrequest(wt),
      .fetch_valid(fv), .fetch_addr(fa), .soft_trap(sw),
      .illegal_opcode_trap(ill), .wdog_overflow(wdo), .src(src),
      .irq_ack(ack), .reti_valid(reti), .reti_ime(1'b1), .irq_req(req),
      .irq_vector(vec), .irq_ime_stacked(ime_st), .core_rst(crst),
      .cpu_start(start), .rst_pin_in_n(pin_n), .rst_pin_out(),
      .rst_pin_oe(poe));
   ric_core_model i_ric_core_model (.mclk(mclk), .rst(rst), .irq_req(req),
      .ack_en(ack_en), .ext_low(ext_low), .rst_pin_oe(poe), .irq_ack(ack),
      .rst_pin_in_n(pin_n));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // accepted vectors, pin-drive length, hang guard
   always @(posedge mclk) begin
      if (ack === 1'b1 && req === 1'b1) acc_q.push_back(vec);
      if (poe === 1'b1) oe_cnt++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one access; held until waitrequest is seen low, one idle edge after
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {16'h0000, d};
      @(posedge mclk);
      while (wt !== 1'b0 && cyc < 20000) @(posedge mclk);
      q = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wait_start();
      int n;
      n = 0;
      while (start !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk({15'h0000, start}, 16'h0001);
      chk(vec, 16'hfffe);
      @(posedge mclk);
   endtask

   task automatic s_reset();
      logic [15:0] q;
      logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
      logic [15:0] rv [5] = '{16'h0, 16'h0, 16'h0003, 16'h0001, 16'h0};
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({15'h0000, poe}, 16'h0001);
      wait_start();
      chk({15'h0000, poe}, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ra[i], 16'h0000, q);
         chk(q, rv[i]);
      end
   endtask

   // every maskable source, both settings of the shared levels
   task automatic s_irq();
      logic [15:0] q;
      int idx;
      bus(1'b1, ric_pkg::OFS_ENABLE, 16'hfff1, q);
      for (int b = 13; b >= 0; b--) begin
         idx = (b >= 4) ? 17 - b : ((b >= 2) ? 14 : 15);
         bus(1'b1, ric_pkg::OFS_CFG, (b == 2 || b == 0) ? 16'h0038 :
             16'h0008, q);
         src <= ric_pkg::ric_src_t'(14'h0001 << b);
         @(posedge mclk);
         src <= '0;
         repeat (2) @(posedge mclk);
         chk(vec, 16'hfffe - 16'(2 * idx));
         bus(1'b0, ric_pkg::OFS_PEND, 16'h0000, q);
         chk(q, 16'h0001 << idx);
         ack_en <= 1'b1;
         repeat (4) @(posedge mclk);
         ack_en <= 1'b0;
         chk(acc_q[$], 16'hfffe - 16'(2 * idx));
         chk({15'h0000, ime_st}, 16'h0001);
         bus(1'b0, ric_pkg::OFS_PEND, 16'h0000, q);
         chk(q, 16'h0000);
         bus(1'b0, ric_pkg::OFS_ENABLE, 16'h0000, q);
         chk(q, 16'hfff0);
         reti <= 1'b1;
         @(posedge mclk);
         reti <= 1'b0;
      end
   endtask

   // traps and maskables at once; master off until the latches are edited
   task automatic s_prio();
      logic [15:0] q;
      logic [15:0] ev [5] = '{16'hfffc, 16'hfffa, 16'hfff8, 16'hfff4,
                              16'hfffc};
      acc_q.delete();
      bus(1'b1, ric_pkg::OFS_ENABLE, 16'hfff0, q);
      bus(1'b1, ric_pkg::OFS_CFG, 16'h0004, q);
      sw <= 1'b1;
      wdo <= 1'b1;
      fv <= 1'b1;
      fa <= 16'h0100;
      src <= ric_pkg::ric_src_t'(14'h3020); // ext0 left gated off
      @(posedge mclk);
      sw <= 1'b0;
      wdo <= 1'b0;
      fv <= 1'b0;
      src <= '0;
      repeat (2) @(posedge mclk);
      bus(1'b0, ric_pkg::OFS_PEND, 16'h0000, q);
      chk(q, 16'h103c);
      bus(1'b1, ric_pkg::OFS_PEND, 16'hefff, q);
      bus(1'b0, ric_pkg::OFS_PEND, 16'h0000, q);
      chk(q, 16'h003c);
      bus(1'b1, ric_pkg::OFS_ENABLE, 16'hfff1, q);
      ack_en <= 1'b1;
      repeat (12) @(posedge mclk);
      reti <= 1'b1;
      @(posedge mclk);
      reti <= 1'b0;
      repeat (6) @(posedge mclk);
      ill <= 1'b1;
      @(posedge mclk);
      ill <= 1'b0;
      repeat (6) @(posedge mclk);
      ack_en <= 1'b0;
      for (int i = 0; i < 5; i++) chk(acc_q[i], ev[i]);
   endtask

   // kind: 0 watchdog, 1 trap fetch, 2 bad clock write, 3 pin held low
   task automatic s_malf(input logic [1:0] kind, input logic [3:0] cause);
      logic [15:0] q;
      bus(1'b1, ric_pkg::OFS_CFG, 16'h0003, q);
      bus(1'b1, ric_pkg::OFS_ENABLE, 16'hfff1, q);
      oe_cnt = 0;
      fa <= 16'h0010;
      if (kind == 2'd0) wdo <= 1'b1;
      if (kind == 2'd1) fv <= 1'b1;
      // legal switch to slow clock first, then drop the running oscillator
      if (kind == 2'd2) begin
         bus(1'b1, ric_pkg::OFS_SYS, 16'h0007, q);
         bus(1'b0, ric_pkg::OFS_SYS, 16'h0000, q);
         chk(q, 16'h0007);
         bus(1'b1, ric_pkg::OFS_SYS, 16'h0005, q);
      end
      if (kind == 2'd3) ext_low <= 1'b1;
      @(posedge mclk);
      wdo <= 1'b0;
      fv <= 1'b0;
      repeat (16) @(posedge mclk);
      chk({15'h0000, crst}, 16'h0001);
      ext_low <= 1'b0;
      wait_start();
      if (kind != 2'd3) chk(16'(oe_cnt), 16'h0018);
      bus(1'b0, ric_pkg::OFS_STAT, 16'h0000, q);
      chk(q & 16'h000f, {12'h000, cause});
      bus(1'b0, ric_pkg::OFS_ENABLE, 16'h0000, q);
      chk(q, 16'h0000);
      bus(1'b0, ric_pkg::OFS_CFG, 16'h0000, q);
      chk(q, 16'h0003);
   endtask

   initial begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 8'h00;
      wd = 32'h00000000;
      fv = 1'b0;
      fa = 16'h0000;
      sw = 1'b0;
      ill = 1'b0;
      wdo = 1'b0;
      src = '0;
      ack_en = 1'b0;
      ext_low = 1'b0;
      reti = 1'b0;
      s_reset();
      s_irq();
      s_prio();
      s_malf(2'd0, 4'h4);
      s_malf(2'd1, 4'h2);
      s_malf(2'd2, 4'h8);
      s_malf(2'd3, 4'h1);
      print_verdict();
   end
endmodule
`default_nettype wire

// [test/ric_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// core and external reset source as seen from the controller
module ric_core_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic ack_en,
   input wire logic ext_low,
   input wire logic rst_pin_oe,
   output logic irq_ack,
   output logic rst_pin_in_n
);
   // pin is pulled up; whoever pulls low wins
   assign rst_pin_in_n = !(rst_pin_oe || ext_low);
   // single-cycle accept, never twice in a row, so a stale request is skipped
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= ack_en && irq_req && !irq_ack;
      end
   end
endmodule
`default_nettype wire
